// file: logic/tsicm_conn_ctrl.sv
// connection memory, block programming engine and per-frame slot scanner
// assumes host port synchronous to clk_sys, one access per cycle
`timescale 1ns/100ps

// Notes on behaviour
// - bit 14 picks variable or constant delay
// - variable delay sends slot as early as possible
// - variable delay follows the channel difference table
// - constant delay stays selectable with variable enabled
// - low and high words, unused bits zero
// - conversion off makes high word ignored
// - normal mode takes source channel and stream
// - special mode emits message byte bits 10..3
// - block program fills pattern, zeros elsewhere
// - block program lasts at least two frames
// - start bit clears itself on completion
// - clearing start or enable aborts programming
module tsicm_conn_ctrl
    import tsicm_pkg::*;
#(
    parameter int BLK_MIN_CYCLES = BLK_MIN_CYC,
    parameter int FRAME_CYCLES = FRAME_CYC
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [HOST_AW-1:0] hostAddr,
    input wire logic hostWrEn,
    input wire logic hostRdEn,
    input wire logic [15:0] hostWrData,
    output logic [15:0] hostRdData,
    output logic hostRdAck,
    output logic outValid,
    input wire logic outReady,
    output tsicm_desc_s outDesc
);
    localparam int NSLOT = 1 << SLOT_W;
    localparam logic [SLOT_W-1:0] SLOT_LAST = SLOT_W'(NSLOT - 1);
    localparam logic [31:0] BLK_LAST = 32'(BLK_MIN_CYCLES - 1);
    localparam logic [15:0] FRAME_LAST = 16'(FRAME_CYCLES - 1);

    logic [15:0] connLow [NSLOT];
    logic [HIGH_W-1:0] connHigh [NSLOT];

    logic var_delay_global_en_reg;
    logic blkEn_reg;
    logic blkStart_reg;
    logic [PAT_W-1:0] blkPat_reg;
    tsicm_blk_e blkState_reg;
    logic [SLOT_W-1:0] blkIdx_reg;
    logic [31:0] blkTimer_reg;
    tsicm_scan_e scanState_reg;
    logic [SLOT_W-1:0] scanSlot_reg;
    logic [15:0] frameCnt_reg;

    logic isMem;
    logic isHigh;
    logic [SLOT_W-1:0] hostSlot;
    logic wrCtrl;
    logic wrIms;
    logic blkGo;
    logic blkDone;
    logic framePulse;
    logic [15:0] rdMux;
    logic [15:0] scanLow;
    logic [HIGH_W-1:0] scanHigh;
    logic special;
    logic varSel;
    logic [DLY_W-1:0] dlyCalc;

    tsicm_desc_if descIf ();

    // ------------------------------------------------------------
    // host decode
    // ------------------------------------------------------------
    assign isMem = hostAddr[MEM_SEL_BIT];
    assign isHigh = hostAddr[HIGH_SEL_BIT];
    assign hostSlot = hostAddr[SLOT_W-1:0];
    assign wrCtrl = hostWrEn && !isMem && (hostAddr == OFS_CTRL);
    assign wrIms = hostWrEn && !isMem && (hostAddr == OFS_IMS);

    // ------------------------------------------------------------
    // control and mode registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            var_delay_global_en_reg <= CR_VAR_EN_RST;
            blkEn_reg <= CR_BLK_EN_RST;
        end
        else if (wrCtrl)
        begin
            var_delay_global_en_reg <= hostWrData[CR_VAR_EN];
            blkEn_reg <= hostWrData[CR_BLK_EN];
        end
    end

    // a host write in the completion cycle wins over the self-clear
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            blkStart_reg <= IMS_START_RST;
            blkPat_reg <= IMS_PAT_RST;
        end
        else if (wrIms)
        begin
            blkStart_reg <= hostWrData[IMS_START];
            blkPat_reg <= hostWrData[IMS_PAT_LSB +: PAT_W];
        end
        else if (blkDone)
            blkStart_reg <= 1'b0;
    end

    // ------------------------------------------------------------
    // block programming engine
    // ------------------------------------------------------------
    assign blkGo = blkEn_reg && blkStart_reg;
    assign blkDone = (blkState_reg == BLK_HOLD) && blkGo && (blkTimer_reg >= BLK_LAST);

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            blkState_reg <= BLK_IDLE;
            blkIdx_reg <= '0;
            blkTimer_reg <= 32'h0;
        end
        else
        begin
            case (blkState_reg)
                BLK_IDLE:
                begin
                    blkIdx_reg <= '0;
                    blkTimer_reg <= 32'h0;
                    if (blkGo)
                        blkState_reg <= BLK_FILL;
                end
                BLK_FILL:
                begin
                    blkIdx_reg <= blkIdx_reg + SLOT_W'(1);
                    blkTimer_reg <= blkTimer_reg + 32'h1;
                    if (!blkGo)
                        blkState_reg <= BLK_IDLE;
                    else if (blkIdx_reg == SLOT_LAST)
                        blkState_reg <= BLK_HOLD;
                end
                BLK_HOLD:
                begin
                    blkTimer_reg <= blkTimer_reg + 32'h1;
                    if (!blkGo || blkDone)
                        blkState_reg <= BLK_IDLE;
                end
                default:
                    blkState_reg <= BLK_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // connection memory
    // ------------------------------------------------------------
    // host writes are dropped while the engine owns the memory
    always_ff @(posedge clk_sys)
    begin
        if (blkState_reg == BLK_FILL && blkGo)
        begin
            connLow[blkIdx_reg] <= {13'h0000, blkPat_reg};
            connHigh[blkIdx_reg] <= 5'h00;
        end
        else if (hostWrEn && isMem && blkState_reg == BLK_IDLE)
        begin
            if (isHigh)
                connHigh[hostSlot] <= hostWrData[HIGH_W-1:0];
            else
                connLow[hostSlot] <= hostWrData;
        end
    end

    always_comb
    begin
        rdMux = 16'h0000;
        if (isMem && isHigh)
            rdMux = {11'h000, connHigh[hostSlot]};
        else if (isMem)
            rdMux = connLow[hostSlot];
        else if (hostAddr == OFS_CTRL)
            rdMux = {11'h000, var_delay_global_en_reg, blkEn_reg, 3'h0};
        else if (hostAddr == OFS_IMS)
            rdMux = {12'h000, blkPat_reg, blkStart_reg};
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            hostRdAck <= 1'b0;
            hostRdData <= 16'h0000;
        end
        else
        begin
            hostRdAck <= hostRdEn;
            if (hostRdEn)
                hostRdData <= rdMux;
        end
    end

    // ------------------------------------------------------------
    // frame timing and slot scanner
    // ------------------------------------------------------------
    assign framePulse = (frameCnt_reg == FRAME_LAST);

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || framePulse)
            frameCnt_reg <= 16'h0000;
        else
            frameCnt_reg <= frameCnt_reg + 16'h0001;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            scanState_reg <= SCN_WAIT;
            scanSlot_reg <= '0;
        end
        else
        begin
            case (scanState_reg)
                SCN_WAIT:
                begin
                    scanSlot_reg <= '0;
                    if (framePulse && blkState_reg == BLK_IDLE)
                        scanState_reg <= SCN_RUN;
                end
                SCN_RUN:
                begin
                    if (blkState_reg != BLK_IDLE)
                        scanState_reg <= SCN_WAIT;
                    else if (descIf.ready)
                    begin
                        scanSlot_reg <= scanSlot_reg + SLOT_W'(1);
                        if (scanSlot_reg == SLOT_LAST)
                            scanState_reg <= SCN_WAIT;
                    end
                end
                default:
                    scanState_reg <= SCN_WAIT;
            endcase
        end
    end

    // ------------------------------------------------------------
    // slot descriptor
    // ------------------------------------------------------------
    assign scanLow = connLow[scanSlot_reg];
    assign scanHigh = connHigh[scanSlot_reg];
    assign special = scanLow[LOW_SPECIAL];
    // constant delay never depends on the chip-wide enable
    assign varSel = !special && scanLow[LOW_VAR_SEL];

    tsicm_delay_calc #(.CW(CHAN_W), .SW(STREAM_W)) u_delay (
        .varSel(varSel),
        .inChan(scanLow[LOW_CHAN_LSB +: CHAN_W]),
        .outChan(scanSlot_reg[CHAN_W-1:0]),
        .inStream(scanLow[LOW_STREAM_LSB +: STREAM_W]),
        .outStream(scanSlot_reg[SLOT_W-1:CHAN_W]),
        .delayChan(dlyCalc)
    );

    assign descIf.valid = (scanState_reg == SCN_RUN) && (blkState_reg == BLK_IDLE);

    always_comb
    begin
        descIf.data.outStream = scanSlot_reg[SLOT_W-1:CHAN_W];
        descIf.data.outChan = scanSlot_reg[CHAN_W-1:0];
        descIf.data.srcStream = special ? '0 : scanLow[LOW_STREAM_LSB +: STREAM_W];
        descIf.data.srcChan = special ? '0 : scanLow[LOW_CHAN_LSB +: CHAN_W];
        descIf.data.delayChan = special ? '0 : dlyCalc;
        descIf.data.msgMode = special;
        descIf.data.msgByte = special ? scanLow[LOW_MSG_LSB +: 8] : 8'h00;
        descIf.data.lawEn = scanLow[LOW_LAW_EN];
        descIf.data.lawCode = scanLow[LOW_LAW_EN] ? scanHigh : 5'h00;
        descIf.data.dataInvalid = varSel && !var_delay_global_en_reg;
    end

    tsicm_skid_buf u_buf (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .inIf(descIf),
        .outValid(outValid),
        .outReady(outReady),
        .outData(outDesc)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    logic descPush;
    assign descPush = descIf.valid && descIf.ready;

    sequence s_blk_finish;
        blkDone && !wrIms;
    endsequence

    sequence s_start_low_idle;
        !blkStart_reg && blkState_reg == BLK_IDLE;
    endsequence

    a_start_self_clear: assert property (s_blk_finish |=> s_start_low_idle)
        else $error("start bit not cleared after block program");
    a_blk_min_time: assert property (blkDone |-> blkTimer_reg >= BLK_LAST)
        else $error("block program finished too early");
    a_blk_fill_low: assert property (blkState_reg == BLK_FILL && blkGo
        |=> connLow[$past(blkIdx_reg)] == {13'h0000, $past(blkPat_reg)})
        else $error("block program wrote wrong low word");
    a_blk_fill_high: assert property (blkState_reg == BLK_FILL && blkGo
        |=> connHigh[$past(blkIdx_reg)] == 5'h00)
        else $error("block program left high word nonzero");
    a_blk_abort: assert property (blkState_reg != BLK_IDLE && !blkGo
        |=> blkState_reg == BLK_IDLE)
        else $error("block program not aborted");
    a_high_read_zero: assert property (hostRdEn && isMem && isHigh
        |=> hostRdAck && hostRdData[15:HIGH_W] == 11'h000)
        else $error("unused high word bits not zero");
    a_low_read_back: assert property (hostRdEn && isMem && !isHigh && !hostWrEn
        |=> hostRdData == $past(rdMux))
        else $error("low word read mismatch");
    a_law_ignored: assert property (descPush && !descIf.data.lawEn
        |-> descIf.data.lawCode == 5'h00)
        else $error("high word used with conversion off");
    a_msg_byte: assert property (descPush && special
        |-> descIf.data.msgByte == scanLow[10:3])
        else $error("message byte mismatch");
    a_var_range: assert property (descPush && varSel
        |-> descIf.data.delayChan >= DLY_W'(VAR_EARLY_CH)
        && descIf.data.delayChan <= DLY_W'((1 << CHAN_W) + VAR_EARLY_CH))
        else $error("variable delay out of range");
    a_const_range: assert property (descPush && !special && !varSel
        |-> descIf.data.delayChan >= DLY_W'((1 << CHAN_W) + 1)
        && descIf.data.delayChan <= DLY_W'(3 * (1 << CHAN_W) - 1))
        else $error("constant delay out of range");
    a_scan_start: assert property (framePulse && scanState_reg == SCN_WAIT
        && blkState_reg == BLK_IDLE |=> scanState_reg == SCN_RUN && scanSlot_reg == '0)
        else $error("frame scan did not start");
endmodule

// file: logic/tsicm_pkg.sv
// shared constants, field layout and types of the connection memory control
// assumes a single 20 MHz system clock; host port is synchronous to it
package tsicm_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int FRAME_NS = 125000;
    localparam int FRAME_CYC = FRAME_NS / CLK_PERIOD_NS;
    localparam int BLK_MIN_NS = 250000;
    localparam int BLK_MIN_CYC = (BLK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int STREAM_W = 5;
    localparam int CHAN_W = 8;
    localparam int SLOT_W = STREAM_W + CHAN_W;
    localparam int DLY_W = CHAN_W + 2;
    localparam int HIGH_W = 5;
    localparam int PAT_W = 3;
    localparam int HOST_AW = 15;
    localparam int VAR_EARLY_CH = 7;

    // ------------------------------------------------------------
    // host address map
    // ------------------------------------------------------------
    localparam int MEM_SEL_BIT = 14;
    localparam int HIGH_SEL_BIT = 13;
    localparam logic [HOST_AW-1:0] OFS_CTRL = 15'h0000;
    localparam logic [HOST_AW-1:0] OFS_IMS = 15'h0001;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int LOW_LAW_EN = 15;
    localparam int LOW_VAR_SEL = 14;
    localparam int LOW_STREAM_LSB = 9;
    localparam int LOW_CHAN_LSB = 1;
    localparam int LOW_MSG_LSB = 3;
    localparam int LOW_SPECIAL = 0;
    localparam int CR_VAR_EN = 4;
    localparam int CR_BLK_EN = 3;
    localparam int IMS_START = 0;
    localparam int IMS_PAT_LSB = 1;
    localparam logic CR_VAR_EN_RST = 1'b0;
    localparam logic CR_BLK_EN_RST = 1'b0;
    localparam logic IMS_START_RST = 1'b0;
    localparam logic [PAT_W-1:0] IMS_PAT_RST = 3'h0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BLK_IDLE = 3'h1,
        BLK_FILL = 3'h2,
        BLK_HOLD = 3'h4
    } tsicm_blk_e;

    typedef enum logic [1:0] {
        SCN_WAIT = 2'h1,
        SCN_RUN = 2'h2
    } tsicm_scan_e;

    typedef struct packed {
        logic [STREAM_W-1:0] outStream;
        logic [CHAN_W-1:0] outChan;
        logic [STREAM_W-1:0] srcStream;
        logic [CHAN_W-1:0] srcChan;
        logic [DLY_W-1:0] delayChan;
        logic msgMode;
        logic [7:0] msgByte;
        logic lawEn;
        logic [HIGH_W-1:0] lawCode;
        logic dataInvalid;
    } tsicm_desc_s;

endpackage

// file: logic/tsicm_desc_if.sv
// slot descriptor handshake between the scanner and the output buffer
// assumes both ends on clk_sys
`timescale 1ns/100ps
interface tsicm_desc_if;
    import tsicm_pkg::*;
    logic valid;
    logic ready;
    tsicm_desc_s data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// file: logic/tsicm_skid_buf.sv
// two-entry buffer between the slot scanner and the output port
// assumes synchronous active-low reset on clk_sys
`timescale 1ns/100ps
module tsicm_skid_buf
    import tsicm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    tsicm_desc_if.snk inIf,
    output logic outValid,
    input wire logic outReady,
    output tsicm_desc_s outData
);
    tsicm_desc_s slot_reg [2];
    logic [1:0] cnt_reg;
    logic wrPtr_reg;
    logic rdPtr_reg;
    logic push;
    logic pop;

    assign inIf.ready = (cnt_reg != 2'h2);
    assign outValid = (cnt_reg != 2'h0);
    assign outData = slot_reg[rdPtr_reg];
    assign push = inIf.valid && inIf.ready;
    assign pop = outValid && outReady;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            cnt_reg <= 2'h0;
            wrPtr_reg <= 1'b0;
            rdPtr_reg <= 1'b0;
        end
        else
        begin
            if (push)
                wrPtr_reg <= !wrPtr_reg;
            if (pop)
                rdPtr_reg <= !rdPtr_reg;
            if (push && !pop)
                cnt_reg <= cnt_reg + 2'h1;
            else if (pop && !push)
                cnt_reg <= cnt_reg - 2'h1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (push)
            slot_reg[wrPtr_reg] <= inIf.data;
    end
endmodule

// file: logic/tsicm_delay_calc.sv
// throughput delay, in channel times, of one switched slot
// assumes a frame of 2**CHAN_W channels; purely combinational
`timescale 1ns/100ps
module tsicm_delay_calc
    import tsicm_pkg::*;
#(
    parameter int CW = CHAN_W,
    parameter int SW = STREAM_W
)
(
    input wire logic varSel,
    input wire logic [CW-1:0] inChan,
    input wire logic [CW-1:0] outChan,
    input wire logic [SW-1:0] inStream,
    input wire logic [SW-1:0] outStream,
    output logic [CW+1:0] delayChan
);
    localparam logic signed [CW+2:0] FRAME = (CW+3)'(1) << CW;
    localparam logic signed [CW+2:0] EARLY = (CW+3)'(VAR_EARLY_CH);
    logic signed [CW+2:0] diff;
    logic signed [CW+2:0] total;

    assign diff = $signed({3'h0, outChan}) - $signed({3'h0, inChan});

    always_comb
    begin
        if (!varSel)
            total = FRAME + FRAME + diff;
        else if (diff > EARLY)
            total = diff;
        else if (diff == EARLY && outStream >= inStream)
            total = diff;
        else
            total = FRAME + diff;
    end

    assign delayChan = total[CW+1:0];
endmodule

// file: tb/tsicm_host_model.sv
// host processor on the parallel port plus the descriptor receiver
// assumes one clk_sys domain; all requests launched just after a rising edge
`timescale 1ns/100ps
module tsicm_host_model
    import tsicm_pkg::*;
(
    input wire logic clk_sys,
    output logic [HOST_AW-1:0] hostAddr,
    output logic hostWrEn,
    output logic hostRdEn,
    output logic [15:0] hostWrData,
    input wire logic [15:0] hostRdData,
    input wire logic hostRdAck,
    output logic outReady,
    input wire logic stall
);
    logic [1:0] pace = 2'h0;

    initial
    begin
        hostAddr = 15'h0000;
        hostWrEn = 1'b0;
        hostRdEn = 1'b0;
        hostWrData = 16'h0000;
    end

    // receiver refuses one cycle in four, or all while stalled
    always @(posedge clk_sys)
    begin
        pace <= pace + 2'h1;
        outReady <= !stall && (pace != 2'h3);
    end

    // idle bus shows the inverse of the last value
    task automatic wr(input logic [HOST_AW-1:0] a, input logic [15:0] d);
    begin
        @(posedge clk_sys);
        hostAddr <= a;
        hostWrData <= d;
        hostWrEn <= 1'b1;
        @(posedge clk_sys);
        hostWrEn <= 1'b0;
        hostAddr <= ~a;
        hostWrData <= ~d;
    end
    endtask

    task automatic rd(input logic [HOST_AW-1:0] a, output logic [15:0] d, output logic k);
    begin
        @(posedge clk_sys);
        hostAddr <= a;
        hostRdEn <= 1'b1;
        @(posedge clk_sys);
        hostRdEn <= 1'b0;
        @(posedge clk_sys);
        k = hostRdAck;
        d = hostRdData;
        hostAddr <= ~a;
    end
    endtask
endmodule

// file: tb/tb.sv
// self-checking bench of the connection memory control
// assumes the host model drives the port; slot table checked per scan
`timescale 1ns/100ps
module tb;
    import tsicm_pkg::*;
    localparam logic [12:0] SL [7] = '{13'h0309, 13'h0109, 13'h0503, 13'h0501,
        13'h0000, 13'h02FF, 13'h0414};
    localparam logic [15:0] LW [7] = '{16'h4404, 16'h4404, 16'h4C02, 16'h4C06,
        16'h0FFE, 16'h0000, 16'h4814};
    localparam logic [9:0] DL [7] = '{10'h007, 10'h107, 10'h102, 10'h0FE,
        10'h101, 10'h2FF, 10'h00A};
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [HOST_AW-1:0] hostAddr;
    logic hostWrEn;
    logic hostRdEn;
    logic [15:0] hostWrData;
    logic [15:0] hostRdData;
    logic hostRdAck;
    logic outValid;
    logic outReady;
    tsicm_desc_s outDesc;
    logic stall = 1'b0;
    logic monOn = 1'b0;
    logic lastOk = 1'b0;
    logic [12:0] lastSlot = 13'h0000;
    int cyc = 0;
    int error_cnt = 0;
    int n_compared = 0;
    tsicm_desc_s seen [int];

    always #25 clk_sys = ~clk_sys;

    always @(posedge clk_sys) cyc <= cyc + 1;

    tsicm_conn_ctrl #(.BLK_MIN_CYCLES(16), .FRAME_CYCLES(20)) tsicm_conn_ctrl_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .hostAddr(hostAddr), .hostWrEn(hostWrEn),
        .hostRdEn(hostRdEn), .hostWrData(hostWrData), .hostRdData(hostRdData),
        .hostRdAck(hostRdAck), .outValid(outValid), .outReady(outReady), .outDesc(outDesc));

    tsicm_host_model tsicm_host_model_i (
        .clk_sys(clk_sys), .hostAddr(hostAddr), .hostWrEn(hostWrEn), .hostRdEn(hostRdEn),
        .hostWrData(hostWrData), .hostRdData(hostRdData), .hostRdAck(hostRdAck),
        .outReady(outReady), .stall(stall));

    // ------------------------------------------------------------
    // comparison and closing
    // ------------------------------------------------------------
    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string m);
    begin
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t: %s got %0h exp %0h", $time, m, got, exp);
        end
    end
    endtask

    task automatic close_out();
    begin
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask

    task automatic rdc(input logic [HOST_AW-1:0] a, input logic [15:0] e, input string m);
        logic [15:0] d;
        logic k;
    begin
        host_i_rd: tsicm_host_model_i.rd(a, d, k);
        check({k, d}, {1'b1, e}, m);
    end
    endtask

    // descriptors accepted by the receiver, kept by slot
    always @(posedge clk_sys)
    begin
        if (outValid === 1'b1 && outReady === 1'b1)
        begin
            seen[int'({outDesc.outStream, outDesc.outChan})] = outDesc;
            if (monOn && lastOk && {outDesc.outStream, outDesc.outChan} != 13'h0000)
                check({outDesc.outStream, outDesc.outChan}, lastSlot + 13'h0001, "order");
            lastSlot = {outDesc.outStream, outDesc.outChan};
            lastOk = 1'b1;
        end
    end

    task automatic wait_slot(input logic [12:0] s);
        int i;
    begin
        seen.delete(int'(s));
        for (i = 0; i < 30000 && !seen.exists(int'(s)); i++)
            @(posedge clk_sys);
        check(seen.exists(int'(s)), 1, "slot not seen");
    end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
    begin
        check(outValid, 1'b0, "valid after reset");
        check(hostRdData, 16'h0000, "read data after reset");
        rdc(OFS_CTRL, 16'h0000, "control reset");
        rdc(OFS_IMS, 16'h0000, "mode reset");
        rdc(15'h0002, 16'h0000, "unmapped read");
    end
    endtask

    task automatic t_blk_full();
        int t0;
        int i;
        logic [15:0] d;
        logic k;
    begin
        tsicm_host_model_i.wr(OFS_CTRL, 16'h0008);
        tsicm_host_model_i.wr(OFS_IMS, 16'h000B);
        t0 = cyc;
        repeat (100) @(posedge clk_sys);
        check(outValid, 1'b0, "slots sent while filling");
        d = 16'h0001;
        for (i = 0; i < 6000 && d[0] === 1'b1; i++)
            tsicm_host_model_i.rd(OFS_IMS, d, k);
        check(d, 16'h000A, "start bit");
        check(cyc - t0 >= 8192, 1, "fill too short");
        rdc(OFS_CTRL, 16'h0008, "enable kept");
        rdc(15'h4ABC, 16'h0005, "pattern low");
        rdc(15'h6ABC, 16'h0000, "zero high");
    end
    endtask

    task automatic t_blk_abort();
    begin
        tsicm_host_model_i.wr(OFS_IMS, 16'h0005);
        repeat (40) @(posedge clk_sys);
        tsicm_host_model_i.wr(OFS_CTRL, 16'h0000);
        repeat (4) @(posedge clk_sys);
        tsicm_host_model_i.wr(OFS_IMS, 16'h0004);
        rdc(15'h4000, 16'h0002, "early slot");
        rdc(15'h5FFF, 16'h0005, "late slot");
    end
    endtask

    task automatic t_regs();
    begin
        tsicm_host_model_i.wr(15'h6100, 16'hFFF5);
        rdc(15'h6100, 16'h0015, "high unused bits");
        tsicm_host_model_i.wr(15'h4100, 16'hA55A);
        rdc(15'h4100, 16'hA55A, "low word");
    end
    endtask

    task automatic t_switch();
        int i;
    begin
        tsicm_host_model_i.wr(OFS_CTRL, 16'h0010);
        for (i = 0; i < 7; i++)
            tsicm_host_model_i.wr(15'h4000 | HOST_AW'(SL[i]), LW[i]);
        tsicm_host_model_i.wr(15'h6700, 16'h0015);
        tsicm_host_model_i.wr(15'h4700, 16'h8000);
        tsicm_host_model_i.wr(15'h6701, 16'h0015);
        tsicm_host_model_i.wr(15'h4701, 16'h0000);
        tsicm_host_model_i.wr(15'h4600, 16'h0529);
        monOn = 1'b1;
        wait_slot(13'h0000);
        wait_slot(13'h0701);
        for (i = 0; i < 7; i++)
        begin
            check(seen[int'(SL[i])].delayChan, DL[i], "delay");
            check(seen[int'(SL[i])].dataInvalid, 1'b0, "data flagged");
        end
        check({seen[32'h309].srcStream, seen[32'h309].srcChan}, 13'h0202, "source");
        check({seen[32'h600].msgMode, seen[32'h600].msgByte}, 9'h1A5, "message");
        check({seen[32'h700].lawEn, seen[32'h700].lawCode}, 6'h35, "law on");
        check({seen[32'h701].lawEn, seen[32'h701].lawCode}, 6'h00, "law off");
    end
    endtask

    task automatic t_stall();
        tsicm_desc_s d0;
    begin
        @(posedge clk_sys);
        stall <= 1'b1;
        repeat (30) @(posedge clk_sys);
        d0 = outDesc;
        check(outValid, 1'b1, "buffer emptied under stall");
        repeat (8) @(posedge clk_sys);
        check(outDesc, d0, "word changed under stall");
        stall <= 1'b0;
        repeat (40) @(posedge clk_sys);
    end
    endtask

    task automatic t_invalid();
    begin
        tsicm_host_model_i.wr(OFS_CTRL, 16'h0000);
        wait_slot(13'h0000);
        wait_slot(13'h0309);
        check(seen[32'h309].dataInvalid, 1'b1, "variable without enable");
        check(seen[32'h000].dataInvalid, 1'b0, "constant flagged");
        check(seen[32'h000].delayChan, 10'h101, "constant delay");
    end
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_blk_full();
        t_blk_abort();
        t_regs();
        t_switch();
        t_stall();
        t_invalid();
        close_out();
    end

    initial
    begin
        repeat (95000) @(posedge clk_sys);
        error_cnt++;
        $display("ERROR %0t: watchdog expired", $time);
        close_out();
    end
endmodule
